// >>> core/pid_customer_end.sv
`timescale 1ns/1ps
// Purpose: Customer-side unit: learns each pair's number from received bits.
// Assumes: Two-pair or three-pair 2048 kbit/s system; six-frame runs.
// Notes:   Transparency rises once every installed pair holds a unique pattern and the patterns in use form the full set for the system size.
//
// Function
// [R1] Only multi-pair 2048 kbit/s systems use this.
// [R2] Each installed pair evaluated independently.
// [R3] Regenerator forwards indicator bits unchanged.
// [R4] Exchange pairs preset numbers 1..3 or 1..2.
// [R5] Customer pair number learnt from received bits.
// [R6] Exchange loads bits on active state.
// [R7] Three-pair: one-hot bit at position m.
// [R8] Two-pair: 1,0 and 0,1.
// [R9] Customer sends all ones until matched.
// [R10] Customer examines bits only when active.
// [R11] Six valid frames, pattern unused elsewhere.
// [R12] Customer echoes matched pattern whole activation.
// [R13] Customer transparent after complete valid matrix.
// [R14] Exchange first sees all ones returned.
// [R15] Exchange acknowledges own pattern six frames.
// [R16] Exchange transparent after all pairs acknowledged.
// [R17] At least twelve frames before transparency.
// [R18] Bad frame restarts count; inactive clears.
module pid_customer_end (
  // Clock and reset.
  input  wire logic                          mclk,
  input  wire logic                          reset,
  // Configuration.
  input  wire logic                          three_pair,
  input  wire logic [pid_pkg::PID_PAIRS-1:0] installed,
  // Link.
  pid_link_if.customer                       link,
  // User side.
  output logic                               transparent,
  output logic [1:0]                         pair_num [pid_pkg::PID_PAIRS]
);
  import pid_pkg::*;
  typedef struct packed {
    logic [PID_PAIRS-1:0]       done;
    pid_zbits_t [PID_PAIRS-1:0] echo;
    logic [PID_PAIRS-1:0][1:0]  num;
    logic                       transp;
  } pid_cus_t;
  // Every pair sends all ones back until it has matched a pattern.
  localparam pid_cus_t PID_CUS_RESET = '{
    done:   '0,
    echo:   {PID_PAIRS{PID_ALL_ONES}},
    num:    '0,
    transp: 1'b0
  };

  // Turns a one-hot indicator pattern back into its pair number.
  function automatic logic [1:0] pid_num_of(input pid_zbits_t z);
    case (z)
      PID_PAT_ONE:   pid_num_of = PID_NUM_ONE;
      PID_PAT_TWO:   pid_num_of = PID_NUM_TWO;
      PID_PAT_THREE: pid_num_of = PID_NUM_THREE;
      default:       pid_num_of = PID_NUM_NONE;
    endcase
  endfunction

  // Gives the set of patterns that forms a complete matrix for the system size.
  function automatic pid_zbits_t pid_full_set(input logic three_pair_sys);
    if (three_pair_sys) begin
      pid_full_set = PID_PAT_ONE | PID_PAT_TWO | PID_PAT_THREE;
    end else begin
      pid_full_set = PID_PAT_ONE | PID_PAT_TWO;
    end
  endfunction

  pid_cus_t st_ff;
  pid_cus_t nxt_st;
  logic [PID_PAIRS-1:0] hit;
  pid_zbits_t           run_pat [PID_PAIRS];

  genvar g;
  generate
    for (g = 0; g < PID_PAIRS; g++) begin : gen_pair
      pid_run_counter u_cnt (
        .mclk    (mclk),
        .reset   (reset),
        .clear   (!link.pair_active_cus[g] || st_ff.done[g]), // see [R10] see [R18]
        .tick    (link.frame_tick),
        .ok      (pid_valid(link.z_down[g], three_pair)), // see [R1] see [R7] see [R8]
        .pat     (link.z_down[g]),
        .hit     (hit[g]),
        .run_pat (run_pat[g])
      );
      assign link.z_up[g] = st_ff.echo[g]; // see [R9] see [R12]
      assign pair_num[g]  = st_ff.num[g]; // see [R5]
    end
  endgenerate

  always_comb begin
    pid_zbits_t used;
    pid_zbits_t matched;
    logic       all_done;
    used     = PID_NONE;
    matched  = PID_NONE;
    all_done = 1'b1;
    nxt_st   = st_ff;
    for (int i = 0; i < PID_PAIRS; i++) begin
      if (st_ff.done[i]) begin
        used = used | st_ff.echo[i];
      end
    end
    matched = used;
    for (int i = 0; i < PID_PAIRS; i++) begin
      if (!link.pair_active_cus[i]) begin
        nxt_st.done[i] = 1'b0; // see [R18]
        nxt_st.echo[i] = PID_ALL_ONES; // see [R9]
        nxt_st.num[i]  = PID_NUM_NONE;
      end else if (!st_ff.done[i] && hit[i] && ((used & run_pat[i]) == PID_NONE)) begin
        // Lower-numbered pairs claim a pattern first when two match at once.
        nxt_st.done[i] = 1'b1; // see [R11] see [R2]
        nxt_st.echo[i] = run_pat[i]; // see [R12]
        nxt_st.num[i]  = pid_num_of(run_pat[i]); // see [R5]
        used           = used | run_pat[i];
      end
      if (installed[i] && !st_ff.done[i]) begin
        all_done = 1'b0;
      end
    end
    // A complete matrix needs every pattern of the system size in use.
    nxt_st.transp = all_done && (installed != '0) &&
                    (matched == pid_full_set(three_pair)); // see [R13]
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_ff <= PID_CUS_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign transparent = st_ff.transp;
endmodule

// >>> pkg/pid_pkg.sv
// Purpose: Shared constants and types for the pair identification logic.
// Assumes: One frame tick per received/transmitted frame overhead slot.
// Notes:   Indicator bits are carried as a three-bit one-hot vector per pair.
package pid_pkg;
  localparam int          PID_PAIRS     = 3;
  localparam int          PID_ZW        = 3;
  localparam int          PID_CW        = 3;
  localparam logic [2:0]  PID_RUN_LEN   = 3'h6;
  localparam logic [2:0]  PID_CNT_ZERO  = 3'h0;
  localparam logic [2:0]  PID_CNT_ONE   = 3'h1;
  localparam logic [2:0]  PID_ALL_ONES  = 3'h7;
  localparam logic [2:0]  PID_NONE      = 3'h0;
  localparam logic [1:0]  PID_NUM_NONE  = 2'h0;
  localparam logic [1:0]  PID_NUM_ONE   = 2'h1;
  localparam logic [1:0]  PID_NUM_TWO   = 2'h2;
  localparam logic [1:0]  PID_NUM_THREE = 2'h3;
  localparam logic [2:0]  PID_PAT_ONE   = 3'h1;
  localparam logic [2:0]  PID_PAT_TWO   = 3'h2;
  localparam logic [2:0]  PID_PAT_THREE = 3'h4;
  localparam int          PID_FRAME_MS  = 6;
  localparam int          PID_MIN_FRAMES = 12;
  localparam int          PID_MIN_MS    = PID_MIN_FRAMES * PID_FRAME_MS;

  typedef logic [PID_ZW-1:0] pid_zbits_t;

  // Checks one-hot pattern validity for the system size (3-pair or 2-pair).
  function automatic logic pid_valid(input pid_zbits_t z, input logic three_pair);
    if (three_pair) begin
      pid_valid = (z == PID_PAT_ONE) || (z == PID_PAT_TWO) || (z == PID_PAT_THREE);
    end else begin
      pid_valid = (z == PID_PAT_ONE) || (z == PID_PAT_TWO);
    end
  endfunction

  // Maps a pair number 1..3 onto its one-hot indicator pattern.
  function automatic pid_zbits_t pid_pattern(input logic [1:0] num);
    case (num)
      PID_NUM_ONE:   pid_pattern = PID_PAT_ONE;
      PID_NUM_TWO:   pid_pattern = PID_PAT_TWO;
      PID_NUM_THREE: pid_pattern = PID_PAT_THREE;
      default:       pid_pattern = PID_NONE;
    endcase
  endfunction
endpackage

// >>> pkg/pid_link_if.sv
`timescale 1ns/1ps
// Purpose: Per-pair indicator bit carrier between exchange and customer ends.
// Assumes: A regenerator, if present, passes the bits unchanged.
// Notes:   frame_tick marks the overhead slot of each frame on every pair.
interface pid_link_if;
  import pid_pkg::*;
  logic                     frame_tick;
  logic [PID_PAIRS-1:0]     pair_active_xch;
  logic [PID_PAIRS-1:0]     pair_active_cus;
  pid_zbits_t               z_down [PID_PAIRS];
  pid_zbits_t               z_up   [PID_PAIRS];
  modport exchange (output z_down, input z_up, input frame_tick, input pair_active_xch);
  modport customer (input z_down, output z_up, input frame_tick, input pair_active_cus);
endinterface

// >>> core/pid_run_counter.sv
`timescale 1ns/1ps
// Purpose: Counts consecutive frames carrying the same valid pattern.
// Assumes: Inputs come from logic on mclk.
// Notes:   hit rises once the run reaches the required length and stays until a bad frame, a new pattern or clear.
module pid_run_counter (
  // Clock and reset.
  input  wire logic              mclk,
  input  wire logic              reset,
  // Frame stream.
  input  wire logic              clear,
  input  wire logic              tick,
  input  wire logic              ok,
  input  wire pid_pkg::pid_zbits_t pat,
  // Result.
  output logic                   hit,
  output pid_pkg::pid_zbits_t    run_pat
);
  import pid_pkg::*;
  typedef struct packed {
    logic [PID_CW-1:0] cnt;
    pid_zbits_t        pat;
  } pid_rc_t;
  pid_rc_t st_ff;
  pid_rc_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (clear) begin
      nxt_st = '0;
    end else if (tick) begin
      if (!ok) begin
        nxt_st.cnt = PID_CNT_ZERO; // see [R18]
      end else if (pat != st_ff.pat) begin
        nxt_st.cnt = PID_CNT_ONE; // see [R18]
        nxt_st.pat = pat;
      end else if (st_ff.cnt != PID_RUN_LEN) begin
        nxt_st.cnt = st_ff.cnt + PID_CNT_ONE; // see [R11]
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hit     = (st_ff.cnt == PID_RUN_LEN);
  assign run_pat = st_ff.pat;
endmodule

// >>> core/pid_exchange_end.sv
`timescale 1ns/1ps
// Purpose: Exchange-side unit: tags each pair and waits for its echo.
// Assumes: Pair numbers are strapped per transceiver before activation.
// Notes:   Transparency rises once every installed pair is acknowledged.
module pid_exchange_end (
  // Clock and reset.
  input  wire logic                          mclk,
  input  wire logic                          reset,
  // Configuration.
  input  wire logic [pid_pkg::PID_PAIRS-1:0] installed,
  input  wire logic [1:0]                    assigned_num [pid_pkg::PID_PAIRS],
  // Link.
  pid_link_if.exchange                       link,
  // User side.
  output logic                               transparent,
  output logic [pid_pkg::PID_PAIRS-1:0]      acked,
  output logic [pid_pkg::PID_PAIRS-1:0]      saw_all_ones
);
  import pid_pkg::*;
  typedef struct packed {
    logic [PID_PAIRS-1:0] ack;
    logic [PID_PAIRS-1:0] ones;
    pid_zbits_t [PID_PAIRS-1:0] tx;
    logic                 transp;
  } pid_xch_t;
  pid_xch_t st_ff;
  pid_xch_t nxt_st;
  logic [PID_PAIRS-1:0] hit;

  genvar g;
  generate
    for (g = 0; g < PID_PAIRS; g++) begin : gen_pair
      pid_run_counter u_cnt (
        .mclk    (mclk),
        .reset   (reset),
        .clear   (!link.pair_active_xch[g] || st_ff.ack[g]),
        .tick    (link.frame_tick),
        .ok      (link.z_up[g] == st_ff.tx[g] && st_ff.tx[g] != PID_NONE), // see [R15]
        .pat     (link.z_up[g]),
        .hit     (hit[g]),
        .run_pat ()
      );
      assign link.z_down[g] = st_ff.tx[g];
    end
  endgenerate

  always_comb begin
    logic all;
    all    = 1'b1;
    nxt_st = st_ff;
    for (int i = 0; i < PID_PAIRS; i++) begin
      if (!link.pair_active_xch[i]) begin
        nxt_st.ack[i]  = 1'b0; // see [R18]
        nxt_st.ones[i] = 1'b0;
        nxt_st.tx[i]   = PID_NONE;
      end else begin
        nxt_st.tx[i] = pid_pattern(assigned_num[i]); // see [R4] see [R6] see [R7] see [R8]
        if (link.frame_tick && link.z_up[i] == PID_ALL_ONES) begin
          nxt_st.ones[i] = 1'b1; // see [R14]
        end
        if (hit[i]) begin
          nxt_st.ack[i] = 1'b1; // see [R15]
        end
      end
      if (installed[i] && !st_ff.ack[i]) begin
        all = 1'b0;
      end
    end
    nxt_st.transp = all && (installed != '0); // see [R16] see [R17]
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign transparent  = st_ff.transp;
  assign acked        = st_ff.ack;
  assign saw_all_ones = st_ff.ones;
endmodule

// >>> verification/pid_monitor.sv
`timescale 1ns/1ps
// Purpose: Watches the indicator bits on the link between the two ends.
// Assumes: One clock; frame_tick marks each frame.
// Notes:   Timing checks use pair 0; value checks use pairs 0 and 1, and the uniqueness check also uses pair 2.
module pid_monitor (
  // Clock and reset.
  input wire logic                          mclk,
  input wire logic                          reset,
  // Link.
  input wire logic                          frame_tick,
  input wire logic [pid_pkg::PID_PAIRS-1:0] pair_active_xch,
  input wire logic [pid_pkg::PID_PAIRS-1:0] pair_active_cus,
  input wire pid_pkg::pid_zbits_t           z_down [pid_pkg::PID_PAIRS],
  input wire pid_pkg::pid_zbits_t           z_up [pid_pkg::PID_PAIRS]
);
  import pid_pkg::*;
  logic [3:0] run_ff;
  pid_zbits_t last_ff;
  // Counts frames in a row that carry one valid pattern down pair 0.
  always_ff @(posedge mclk) begin
    if (reset || !pair_active_cus[0]) begin
      run_ff <= 4'h0;
    end else if (frame_tick) begin
      run_ff <= !$onehot(z_down[0]) ? 4'h0 :
                (z_down[0] == last_ff && run_ff != 4'hf) ? run_ff + 4'h1 : 4'h1;
    end
    if (frame_tick) begin
      last_ff <= z_down[0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence up_ones6;
    (z_up[0] == PID_ALL_ONES) [*6];
  endsequence
  a_up_idle_ones: assert property (!pair_active_cus[0] |=> z_up[0] == PID_ALL_ONES)
    else $error("echo not all ones while idle");
  a_down_idle_none: assert property (!pair_active_xch[0] |=> z_down[0] == PID_NONE)
    else $error("tag left on idle pair");
  a_down_tag_onehot: assert property (pair_active_xch[1] |=> $onehot(z_down[1]))
    else $error("tag not one-hot");
  a_up_legal_value: assert property (z_up[1] == PID_ALL_ONES || $onehot(z_up[1]))
    else $error("echo value illegal");
  a_up_echo_holds: assert property
    (pair_active_cus[0] && $onehot(z_up[0]) |=> $stable(z_up[0]))
    else $error("echo changed in activation");
  a_up_echo_unique: assert property
    ($onehot(z_up[0]) |-> z_up[0] != z_up[1] && z_up[0] != z_up[2])
    else $error("pattern echoed twice");
  a_up_waits_frames: assert property ($rose(pair_active_cus[0]) |=> up_ones6)
    else $error("echo too early");
  a_up_after_run: assert property
    ($rose($onehot(z_up[0])) |-> run_ff >= 4'h6 && z_up[0] == z_down[0])
    else $error("echo without six frames");
endmodule

// >>> verification/tb_pair_identification_logic.sv
`timescale 1ns/1ps
// Purpose: Brings both ends up over one link and checks the outcome.
// Assumes: Frames spaced at random, exchange activated before customer.
// Notes:   Pair numbers are a random rotation of 1..n.
module tb_pair_identification_logic;
  import pid_pkg::*;
  logic       mclk = 1'b0;
  logic       reset = 1'b1;
  logic       three_pair = 1'b1;
  logic [2:0] installed = 3'h0;
  logic [1:0] assigned_num [PID_PAIRS] = '{default: 2'h0};
  logic       xt;
  logic       ct;
  logic [2:0] acked;
  logic [2:0] saw_ones;
  logic [1:0] pair_num [PID_PAIRS];
  int         fail_count = 0;
  int         n_checks = 0;
  int         seed = 91727;
  int         nf;
  logic       timed_out = 1'b0;
  // The link passes indicator bits unchanged both ways, as a regenerator must.
  pid_link_if lnk ();
  pid_exchange_end i_pid_exchange_end (.mclk(mclk), .reset(reset), .installed(installed),
    .assigned_num(assigned_num), .link(lnk.exchange), .transparent(xt), .acked(acked),
    .saw_all_ones(saw_ones));
  pid_customer_end i_pid_customer_end (.mclk(mclk), .reset(reset), .three_pair(three_pair),
    .installed(installed), .link(lnk.customer), .transparent(ct), .pair_num(pair_num));
  pid_monitor i_pid_monitor (.mclk(mclk), .reset(reset), .frame_tick(lnk.frame_tick),
    .pair_active_xch(lnk.pair_active_xch), .pair_active_cus(lnk.pair_active_cus),
    .z_down(lnk.z_down), .z_up(lnk.z_up));
  always #5 mclk = ~mclk;
  function automatic logic [1:0] exp_num(input int i, input int k, input int n);
    return (i < n) ? 2'((i + k) % n + 1) : 2'h0;
  endfunction
  task automatic chk_flag(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_mask(input string what, input logic [2:0] exp, input logic [2:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_num(input string what, input logic [1:0] exp, input logic [1:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic frame();
    @(negedge mclk) lnk.frame_tick = 1'b1;
    @(negedge mclk) lnk.frame_tick = 1'b0;
    repeat ($unsigned($random(seed)) % 3) @(negedge mclk);
  endtask
  task automatic run(input logic tp);
    int n;
    int k;
    n = tp ? 3 : 2;
    k = $unsigned($random(seed)) % n;
    @(negedge mclk);
    three_pair = tp;
    installed = tp ? 3'h7 : 3'h3;
    for (int i = 0; i < PID_PAIRS; i++) begin
      assigned_num[i] = exp_num(i, k, n);
    end
    lnk.pair_active_xch = installed;
    repeat (3) frame();
    chk_mask("saw_all_ones", installed, saw_ones);
    chk_flag("cus_transparent", 1'b0, ct);
    lnk.pair_active_cus = installed;
    nf = 0;
    while (xt !== 1'b1 && nf < 40) begin
      frame();
      nf++;
    end
    if (xt !== 1'b1) begin
      chk_flag("xch_transparent", 1'b1, xt);
      timed_out = 1'b1;
      return;
    end
    chk_flag("frames_12", 1'b1, nf >= PID_MIN_FRAMES);
    chk_flag("cus_transparent", 1'b1, ct);
    chk_mask("acked", installed, acked);
    for (int i = 0; i < n; i++) begin
      chk_num("pair_num", exp_num(i, k, n), pair_num[i]);
    end
    lnk.pair_active_xch = 3'h0;
    lnk.pair_active_cus = 3'h0;
    repeat (3) @(negedge mclk);
    chk_flag("xch_transparent", 1'b0, xt);
    chk_mask("acked", 3'h0, acked);
    chk_flag("cus_transparent", 1'b0, ct);
    $display("run done three_pair %0d rotation %0d frames %0d", tp, k, nf);
  endtask
  initial begin
    lnk.frame_tick = 1'b0;
    lnk.pair_active_xch = 3'h0;
    lnk.pair_active_cus = 3'h0;
    repeat (10) @(negedge mclk);
    reset = 1'b0;
    run(1'b1);
    if (!timed_out) begin
      run(1'b0);
    end
    repeat (4) begin
      if (!timed_out) begin
        run(1'($random(seed)));
      end
    end
    conclude();
  end
endmodule
